/* design/ccs_clock_select.sv */
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources
  input wire logic [ccs_pkg::NUM_OUT-1:0] dedicated_input_source,
  input wire logic [ccs_pkg::NUM_OUT-1:0] fabric_input_source,
  input wire logic crystal_osc_source,
  input wire logic slow_rc_osc_source,
  input wire logic fast_rc_osc_source,
  // fabric controls
  input wire logic loop_bypass_n,
  input wire logic [ccs_pkg::NUM_OUT-1:0] glitchless_select_input,
  input wire logic [ccs_pkg::NUM_OUT-1:0] global_output_gate_enable,
  // clock outputs
  output logic [ccs_pkg::NUM_OUT-1:0] global_output,
  output logic [ccs_pkg::NUM_OUT-1:0] local_output,
  output logic [ccs_pkg::NUM_OUT-1:0] divider_output,
  // delay line settings
  output logic [ccs_pkg::STEP_W-1:0] reference_delay_line,
  output logic [ccs_pkg::STEP_W-1:0] feedback_delay_line,
  output logic delay_lines_bypassed
);
  import ccs_pkg::*;

  // ---------------------------------------------------------------
  // selector decoding
  // ---------------------------------------------------------------

  // reference selector; unlisted codes give zero
  function automatic logic ref_pick(input logic [3:0] code, input logic [3:0] ded,
                                    input logic [3:0] fab, input logic [2:0] osc);
    logic v;
    v = 1'b0;
    if (code <= RF_DED_LAST) begin
      v = ded[code[1:0]];
    end else if (code == RF_ZERO) begin
      v = 1'b0;
    end else if (code == RF_XTAL) begin
      v = osc[0];
    end else if (code == RF_SLOW) begin
      v = osc[1];
    end else if (code == RF_FAST) begin
      v = osc[2];
    end else if (code >= RF_FAB_BASE) begin
      v = fab[code[1:0]];
    end
    return v;
  endfunction

  // feedback selector; code 7 takes the zero-degree tap
  function automatic logic fb_pick(input logic [3:0] code, input logic [3:0] ded,
                                   input logic [3:0] fab, input logic tap0);
    logic v;
    v = 1'b0;
    if (code <= RF_DED_LAST) begin
      v = ded[code[1:0]];
    end else if (code == FB_TAP0) begin
      v = tap0;
    end else if (code >= RF_FAB_BASE) begin
      v = fab[code[1:0]];
    end
    return v;
  endfunction

  // divider and output selectors share one table; only outputs see dividers
  function automatic logic src_pick(input logic [4:0] code, input logic [7:0] taps,
                                    input logic [3:0] ded, input logic [3:0] fab,
                                    input logic [2:0] osc, input logic [3:0] divo,
                                    input logic allow_div);
    logic v;
    v = 1'b0;
    if (code <= SS_TAP_LAST) begin
      v = taps[3'h7 - code[2:0]];
    end else if (allow_div && code >= SS_DIV_BASE && code <= SS_DIV_LAST) begin
      v = divo[code[1:0]];
    end else if (code >= SS_DED_BASE && code <= SS_DED_LAST) begin
      v = ded[code[1:0]];
    end else if (code > SS_DED_LAST && code <= SS_FAB_LAST) begin
      v = fab[code[1:0]];
    end else if (code == SS_XTAL) begin
      v = osc[0];
    end else if (code == SS_SLOW) begin
      v = osc[1];
    end else if (code == SS_FAST) begin
      v = osc[2];
    end
    return v;
  endfunction

  function automatic logic uses_tap(input logic [4:0] code);
    return code <= SS_TAP_LAST;
  endfunction

  // true for a word slot of a four-deep register group, false for any other address
  function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
    return (addr >= base) && (addr < base + 8'h10) && (addr[1:0] == 2'h0);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] delay_reg;
  logic [3:0] ref_sel_reg;
  logic [3:0] fb_sel_reg;
  logic int_fb_reg;
  logic [NUM_OUT-1:0][4:0] pri_reg;
  logic [NUM_OUT-1:0][4:0] sec_reg;
  logic [NUM_OUT-1:0] sec_en_reg;
  logic [NUM_OUT-1:0] inv_reg;
  logic [NUM_OUT-1:0] gate_opt_reg;
  logic [NUM_OUT-1:0][4:0] dsrc_reg;
  logic [NUM_OUT-1:0][7:0] dval_reg;
  logic [NUM_OUT-1:0] use_sec_reg;
  logic [2:0] phase_reg;
  logic ref_prev_reg;
  logic fb_seen_reg;
  logic [31:0] rd_next;
  logic addr_hit;
  logic [1:0] slot;
  logic wr_go;
  logic [2:0] osc;
  logic ref_clk;
  logic fb_clk;
  logic loop_needed;
  logic loop_on;
  logic [NUM_TAP-1:0] taps;
  logic [NUM_OUT-1:0] div_src;

  assign osc = {fast_rc_osc_source, slow_rc_osc_source, crystal_osc_source};
  assign wr_go = psel && penable && pwrite && addr_hit;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // ---------------------------------------------------------------
  // bus read decode
  // ---------------------------------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000;
    addr_hit = 1'b1;
    slot = paddr[3:2] - 2'h2;
    if (paddr == OFF_DELAY) begin
      rd_next[7:0] = {1'b0, delay_reg[6:0]}; // top bit reads as zero
    end else if (paddr == OFF_SRC) begin
      rd_next[REF_SEL_LSB +: 4] = ref_sel_reg;
      rd_next[FB_SEL_LSB +: 4] = fb_sel_reg;
      rd_next[INT_FB_BIT] = int_fb_reg;
    end else if (paddr == OFF_STATUS) begin
      rd_next[ST_REFERENCE_DELAY_LINE_LSB +: STEP_W] = reference_delay_line;
      rd_next[ST_FEEDBACK_DELAY_LINE_LSB +: STEP_W] = feedback_delay_line;
      rd_next[ST_BYP_BIT] = delay_lines_bypassed;
      rd_next[ST_LOOP_BIT] = loop_on;
      rd_next[ST_FB_BIT] = fb_seen_reg;
      rd_next[ST_SEC_LSB +: NUM_OUT] = use_sec_reg;
    end else if (in_group(paddr, OFF_OUTCFG0)) begin
      slot = paddr[3:2] - 2'h2;
      rd_next[PRI_LSB +: 5] = pri_reg[slot];
      rd_next[SEC_LSB +: 5] = sec_reg[slot];
      rd_next[SEC_EN_BIT] = sec_en_reg[slot];
      rd_next[INV_BIT] = inv_reg[slot];
      rd_next[GATE_OPT_BIT] = gate_opt_reg[slot];
    end else if (in_group(paddr, OFF_DIVCFG0)) begin
      slot = paddr[3:2] - 2'h2;
      rd_next[DSRC_LSB +: 5] = dsrc_reg[slot];
      rd_next[DVAL_LSB +: 8] = dval_reg[slot];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // read data captured in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // configuration writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_reg <= RST_DELAY;
      ref_sel_reg <= RST_REF_SEL;
      fb_sel_reg <= RST_FB_SEL;
      int_fb_reg <= RST_INT_FB;
      for (int i = 0; i < NUM_OUT; i++) begin
        pri_reg[i] <= RST_PRI;
        sec_reg[i] <= RST_SEC;
        dsrc_reg[i] <= RST_DSRC;
        dval_reg[i] <= RST_DVAL;
      end
      sec_en_reg <= '0;
      inv_reg <= '0;
      gate_opt_reg <= '0;
    end else if (wr_go) begin
      if (paddr == OFF_DELAY) begin
        delay_reg <= {1'b0, pwdata[6:0]};
      end else if (paddr == OFF_SRC) begin
        ref_sel_reg <= pwdata[REF_SEL_LSB +: 4];
        fb_sel_reg <= pwdata[FB_SEL_LSB +: 4];
        int_fb_reg <= pwdata[INT_FB_BIT];
      end else if (in_group(paddr, OFF_OUTCFG0)) begin
        pri_reg[slot] <= pwdata[PRI_LSB +: 5];
        sec_reg[slot] <= pwdata[SEC_LSB +: 5];
        sec_en_reg[slot] <= pwdata[SEC_EN_BIT];
        inv_reg[slot] <= pwdata[INV_BIT];
        gate_opt_reg[slot] <= pwdata[GATE_OPT_BIT];
      end else if (in_group(paddr, OFF_DIVCFG0)) begin
        dsrc_reg[slot] <= pwdata[DSRC_LSB +: 5];
        dval_reg[slot] <= pwdata[DVAL_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // delay line routing
  // ---------------------------------------------------------------
  // the delay elements sit outside the short loop feedback path, so that
  // path leaves nothing to program
  always_comb begin
    reference_delay_line = '0;
    feedback_delay_line = '0;
    delay_lines_bypassed = 1'b1;
    if (int_fb_reg) begin
      delay_lines_bypassed = 1'b1;
    end else if (delay_reg[STEP_W-1:0] == '0) begin
      delay_lines_bypassed = 1'b1;
    end else if (delay_reg[DLY_PATH_BIT]) begin
      reference_delay_line = delay_reg[STEP_W-1:0];
      delay_lines_bypassed = 1'b0;
    end else begin
      feedback_delay_line = delay_reg[STEP_W-1:0];
      delay_lines_bypassed = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // loop model
  // ---------------------------------------------------------------
  assign ref_clk = ref_pick(ref_sel_reg, dedicated_input_source, fabric_input_source, osc);
  assign fb_clk = fb_pick(fb_sel_reg, dedicated_input_source, fabric_input_source, taps[0]);

  // the loop only runs when some output, directly or through a divider, uses a tap
  always_comb begin
    loop_needed = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (uses_tap(pri_reg[i]) || (sec_en_reg[i] && uses_tap(sec_reg[i])))
        loop_needed = 1'b1;
      if (pri_reg[i] >= SS_DIV_BASE && pri_reg[i] <= SS_DIV_LAST &&
          uses_tap(dsrc_reg[pri_reg[i][1:0]]))
        loop_needed = 1'b1;
      if (sec_en_reg[i] && sec_reg[i] >= SS_DIV_BASE && sec_reg[i] <= SS_DIV_LAST &&
          uses_tap(dsrc_reg[sec_reg[i][1:0]]))
        loop_needed = 1'b1;
    end
  end

  assign loop_on = loop_needed && loop_bypass_n;

  // phase counter restarts at each reference rise so taps stay referenced to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 3'h0;
      ref_prev_reg <= 1'b0;
      fb_seen_reg <= 1'b0;
    end else begin
      ref_prev_reg <= ref_clk;
      fb_seen_reg <= fb_clk;
      if (!loop_on || (ref_clk && !ref_prev_reg)) begin
        phase_reg <= 3'h0;
      end else begin
        phase_reg <= phase_reg + 3'h1;
      end
    end
  end

  // tap k lags tap 0 by k eighths of a period; bypassed taps follow the reference
  generate
    for (genvar k = 0; k < NUM_TAP; k++) begin : g_tap
      assign taps[k] = loop_on ? (3'(phase_reg - 3'(k)) < TAP_HALF)
                               : ref_clk;
    end
  endgenerate

  // ---------------------------------------------------------------
  // output dividers
  // ---------------------------------------------------------------
  generate
    for (genvar d = 0; d < NUM_OUT; d++) begin : g_div
      assign div_src[d] = src_pick(dsrc_reg[d], taps, dedicated_input_source,
                                   fabric_input_source, osc, 4'h0, 1'b0);
      ccs_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clk_in(div_src[d]),
        .div_value(dval_reg[d]),
        .clk_out(divider_output[d])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // glitch-free selectors, inversion and gating per output
  // ---------------------------------------------------------------
  generate
    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
      ccs_glitch_e st_reg;
      logic pri_v;
      logic sec_v;
      logic want;
      logic cur_v;
      logic new_v;
      logic mux_v;
      logic inv_v;
      logic gate_on_reg;

      assign pri_v = src_pick(pri_reg[o], taps, dedicated_input_source, fabric_input_source,
                              osc, divider_output, 1'b1);
      assign sec_v = src_pick(sec_reg[o], taps, dedicated_input_source, fabric_input_source,
                              osc, divider_output, 1'b1);
      assign want = sec_en_reg[o] && glitchless_select_input[o];
      assign cur_v = use_sec_reg[o] ? sec_v : pri_v;
      assign new_v = want ? sec_v : pri_v;

      // switch only with the old clock low, then hold low until the new one is low
      always_comb begin
        case (st_reg)
          GF_RUN: mux_v = cur_v;
          GF_PARK: mux_v = cur_v;
          default: mux_v = 1'b0;
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg <= GF_RUN;
          use_sec_reg[o] <= 1'b0;
        end else begin
          case (st_reg)
            GF_RUN: begin
              if (want != use_sec_reg[o]) begin
                st_reg <= cur_v ? GF_PARK : GF_WAIT;
              end
            end
            GF_PARK: begin
              if (!cur_v) begin
                st_reg <= GF_WAIT;
              end
            end
            default: begin
              if (!new_v) begin
                use_sec_reg[o] <= want;
                st_reg <= GF_RUN;
              end
            end
          endcase
        end
      end

      // inversion after the selector covers both sources alike
      assign inv_v = mux_v ^ inv_reg[o];

      // gate state changes only while the clock is low, so no runt pulse escapes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gate_on_reg <= 1'b1;
        end else if (!inv_v) begin
          gate_on_reg <= !gate_opt_reg[o] || global_output_gate_enable[o];
        end
      end

      // every output exists as both a gated global and a free local copy
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          global_output[o] <= 1'b0;
          local_output[o] <= 1'b0;
        end else begin
          global_output[o] <= inv_v && gate_on_reg;
          local_output[o] <= inv_v;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* design/ccs_pkg.sv */
package ccs_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int NUM_TAP = 8;
  localparam int STEP_W = 6;

  // ---------------------------------------------------------------
  // register byte offsets (one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DELAY = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_OUTCFG0 = 8'h08;
  localparam logic [7:0] OFF_DIVCFG0 = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h28;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DLY_PATH_BIT = 6;
  localparam int REF_SEL_LSB = 0;
  localparam int FB_SEL_LSB = 4;
  localparam int INT_FB_BIT = 8;
  localparam int PRI_LSB = 0;
  localparam int SEC_LSB = 5;
  localparam int SEC_EN_BIT = 10;
  localparam int INV_BIT = 11;
  localparam int GATE_OPT_BIT = 12;
  localparam int DSRC_LSB = 0;
  localparam int DVAL_LSB = 8;
  localparam int ST_REFERENCE_DELAY_LINE_LSB = 0;
  localparam int ST_FEEDBACK_DELAY_LINE_LSB = 8;
  localparam int ST_BYP_BIT = 14;
  localparam int ST_LOOP_BIT = 16;
  localparam int ST_FB_BIT = 17;
  localparam int ST_SEC_LSB = 20;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [3:0] RST_REF_SEL = 4'h0;
  localparam logic [3:0] RST_FB_SEL = 4'h7;
  localparam logic RST_INT_FB = 1'b0;
  localparam logic [4:0] RST_PRI = 5'h07;
  localparam logic [4:0] RST_SEC = 5'h07;
  localparam logic [4:0] RST_DSRC = 5'h07;
  localparam logic [7:0] RST_DVAL = 8'h01;

  // ---------------------------------------------------------------
  // selector codes
  // ---------------------------------------------------------------
  localparam logic [3:0] RF_DED_LAST = 4'h3;
  localparam logic [3:0] FB_TAP0 = 4'h7;
  localparam logic [3:0] RF_ZERO = 4'h8;
  localparam logic [3:0] RF_XTAL = 4'h9;
  localparam logic [3:0] RF_SLOW = 4'hA;
  localparam logic [3:0] RF_FAST = 4'hB;
  localparam logic [3:0] RF_FAB_BASE = 4'hC;
  localparam logic [4:0] SS_TAP_LAST = 5'h07;
  localparam logic [4:0] SS_DIV_BASE = 5'h08;
  localparam logic [4:0] SS_DIV_LAST = 5'h0B;
  localparam logic [4:0] SS_DED_BASE = 5'h10;
  localparam logic [4:0] SS_DED_LAST = 5'h13;
  localparam logic [4:0] SS_FAB_LAST = 5'h17;
  localparam logic [4:0] SS_ZERO = 5'h18;
  localparam logic [4:0] SS_XTAL = 5'h19;
  localparam logic [4:0] SS_SLOW = 5'h1A;
  localparam logic [4:0] SS_FAST = 5'h1B;

  // ---------------------------------------------------------------
  // loop tap model: eight phases over one period of twice this many cycles
  // ---------------------------------------------------------------
  localparam logic [2:0] TAP_HALF = 3'h4;

  typedef enum logic [1:0] {GF_RUN, GF_PARK, GF_WAIT} ccs_glitch_e;

endpackage

/* design/ccs_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_divider (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // divided clock path
  input wire logic clk_in,
  input wire logic [7:0] div_value,
  output logic clk_out
);
  import ccs_pkg::*;

  logic prev_reg;
  logic tog_reg;
  logic tog_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic edge_seen;

  // count both edges: a half period is div_value edges, so odd factors work too
  assign edge_seen = clk_in ^ prev_reg;

  always_comb begin
    tog_next = tog_reg;
    cnt_next = cnt_reg;
    if (edge_seen) begin
      if (cnt_reg >= div_value - 8'h01) begin
        cnt_next = 8'h00;
        tog_next = ~tog_reg;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  // edge history and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
      tog_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      prev_reg <= clk_in;
      tog_reg <= tog_next;
      cnt_reg <= cnt_next;
    end
  end

  // factor 0 or 1 passes the source through, otherwise the toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out <= 1'b0;
    end else if (div_value <= 8'h01) begin
      clk_out <= clk_in;
    end else begin
      clk_out <= tog_next;
    end
  end

endmodule
`default_nettype wire

/* verif/ccs_clock_select_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_select_monitor (
  // bus side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // clock and delay side
  input wire logic [3:0] global_output_gate_enable,
  input wire logic [3:0] global_output,
  input wire logic [3:0] local_output,
  input wire logic [5:0] reference_delay_line,
  input wire logic [5:0] feedback_delay_line,
  input wire logic delay_lines_bypassed
);
  logic [6:0] dly_reg;
  logic ifb_reg;
  logic [12:0] oc0_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  // shadow words, taken at the same edge the slave takes a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_reg <= 7'h00;
      ifb_reg <= 1'b0;
      oc0_reg <= 13'h0007;
    end else if (psel && penable && pwrite) begin
      if (paddr == 8'h00) dly_reg <= pwdata[6:0];
      if (paddr == 8'h04) ifb_reg <= pwdata[8];
      if (paddr == 8'h08) oc0_reg <= pwdata[12:0];
    end
  end
  a_ref_delay: assert property (
    reference_delay_line == ((dly_reg[6] && !ifb_reg) ? dly_reg[5:0] : 6'h00))
    else $error("reference delay setting wrong");
  a_fb_delay: assert property (
    feedback_delay_line == ((!dly_reg[6] && !ifb_reg) ? dly_reg[5:0] : 6'h00))
    else $error("feedback delay setting wrong");
  a_bypass_zero: assert property (
    delay_lines_bypassed == (reference_delay_line == 6'h00 && feedback_delay_line == 6'h00))
    else $error("bypass flag disagrees with delay settings");
  a_status_delay: assert property (
    s_acc ##0 (!pwrite && paddr == 8'h28) |->
    prdata[14:0] == {delay_lines_bypassed, feedback_delay_line, 2'b00, reference_delay_line})
    else $error("status word disagrees with delay outputs");
  a_gate_stop: assert property (
    (oc0_reg[12] && !global_output_gate_enable[0]) [*4] |-> !global_output[0])
    else $error("gated global output still running");
  a_invert_zero: assert property (
    (oc0_reg[4:0] == 5'h18 && oc0_reg[11]) [*3] |-> local_output[0])
    else $error("inverted constant zero not high");
  a_zero_code: assert property (
    (oc0_reg[4:0] == 5'h18 && oc0_reg[11:10] == 2'b00) [*3] |-> !local_output[0])
    else $error("zero source code not low");
  a_reserved_zero: assert property (
    (oc0_reg[4:3] == 2'b11 && oc0_reg[2] && oc0_reg[11:10] == 2'b00) [*3] |-> !local_output[0])
    else $error("reserved source code not low");
endmodule
bind ccs_clock_select ccs_clock_select_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .global_output_gate_enable(global_output_gate_enable), .global_output(global_output),
  .local_output(local_output), .reference_delay_line(reference_delay_line),
  .feedback_delay_line(feedback_delay_line), .delay_lines_bypassed(delay_lines_bypassed)
);
`default_nettype wire

/* verif/ccs_fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_fabric_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // clocks to and from the conditioner; arm and result of the run check
  input wire logic arm,
  input wire logic watch_clk,
  output logic [3:0] fab_clk,
  output int min_run
);
  logic [1:0] div_cnt;
  logic last;
  int run;
  // fabric clocks of six cycles; fabric logic runs them free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
      fab_clk <= 4'h0;
    end else begin
      div_cnt <= (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
      if (div_cnt == 2'h2) fab_clk <= ~fab_clk;
    end
  end
  // shortest level run seen; a one-cycle run means a glitch, as sources last two
  always_ff @(posedge pclk) begin
    last <= watch_clk;
    if (!arm) begin
      run <= 99;
      min_run <= 99;
    end else if (watch_clk != last) begin
      run <= 1;
      if (run < min_run) min_run <= run;
    end else begin
      run <= run + 1;
    end
  end
endmodule
`default_nettype wire

/* verif/ccs_clock_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_select_tb;
  import ccs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lbn = 1, arm = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, byp;
  logic [3:0] ded = 0, gsel = 0, gen = 4'hF, fab, gout, lout, dout, cnt = 0;
  logic [5:0] rdl, fdl;
  logic [6:0] c;
  int seed, i, bad_count = 0, n_tests = 0, min_run;
  ccs_clock_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dedicated_input_source(ded), .fabric_input_source(fab),
    .crystal_osc_source(cnt[2]), .slow_rc_osc_source(cnt[3]), .fast_rc_osc_source(cnt[0]),
    .loop_bypass_n(lbn), .glitchless_select_input(gsel), .global_output_gate_enable(gen),
    .global_output(gout), .local_output(lout), .divider_output(dout),
    .reference_delay_line(rdl), .feedback_delay_line(fdl), .delay_lines_bypassed(byp));
  ccs_fabric_model u_fab (.pclk(pclk), .presetn(presetn), .arm(arm),
    .watch_clk(gout[1]), .fab_clk(fab), .min_run(min_run));
  initial forever #20 pclk = ~pclk;
  // dedicated inputs: four-cycle period, so every level lasts two cycles
  always @(posedge pclk) begin
    cnt <= cnt + 4'h1;
    ded <= {4{cnt[1]}};
  end
  function automatic logic [31:0] exp_dly(input logic [6:0] v, input logic ifb);
    exp_dly = ifb ? 32'h0 : v[6] ? {26'h0, v[5:0]} : {20'h0, v[5:0], 6'h00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one transfer: setup, access held until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    seed = 31;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFF_SRC, 0); chk("src word", {23'h0, RST_INT_FB, RST_FB_SEL, RST_REF_SEL}, q);
    apb(0, OFF_OUTCFG0, 0); chk("out word", {22'h0, RST_SEC, RST_PRI}, q);
    apb(0, OFF_DIVCFG0, 0); chk("div word", {16'h0, RST_DVAL, 3'h0, RST_DSRC}, q);
    apb(0, OFF_STATUS, 0); chk("status", 32'h0001_4000, q & 32'h0001_7FFF);
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      c = (i == 0) ? 7'h40 : 7'($random(seed));
      apb(1, OFF_DELAY, {25'h0, c});
      chk("delay lines", exp_dly(c, 1'b0), {20'h0, fdl, rdl});
      chk("bypassed", {31'h0, c[5:0] == 6'h00}, {31'h0, byp});
    end
    apb(1, OFF_SRC, 32'h170);
    chk("internal feedback", exp_dly(c, 1'b1), {20'h0, fdl, rdl});
    apb(1, OFF_SRC, 32'h070);
    apb(0, 8'h2C, 0); chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test delay done");
    apb(1, OFF_OUTCFG0, 32'h818);
    repeat (4) @(posedge pclk);
    chk("inverted zero", 32'h3, {30'h0, gout[0], lout[0]});
    apb(1, OFF_OUTCFG0, 32'h18);
    repeat (4) @(posedge pclk);
    chk("zero code", 32'h0, {31'h0, lout[0]});
    // gate a running source: the gate only moves while the clock is low
    apb(1, OFF_OUTCFG0, 32'h1810);
    gen <= 4'hE;
    repeat (4) @(posedge pclk);
    e = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      e = e | gout[0];
    end
    chk("gated out", 32'h0, {31'h0, e});
    gen <= 4'hF;
    repeat (4) @(posedge pclk);
    e = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      e = e | gout[0];
    end
    chk("ungated out", 32'h1, {31'h0, e});
    apb(1, OFF_OUTCFG0, 32'h1F);
    repeat (4) @(posedge pclk);
    chk("reserved code", 32'h0, {31'h0, lout[0]});
    $display("test gate done");
    for (i = 0; i < 4; i++) apb(1, OFF_OUTCFG0 + 8'(4 * i), 32'h10);
    for (i = 0; i < 4; i++) apb(1, OFF_DIVCFG0 + 8'(4 * i), 32'h118);
    apb(0, OFF_STATUS, 0); chk("loop off", 32'h0, {31'h0, q[16]});
    apb(1, OFF_OUTCFG0 + 8'h08, 32'hE7);
    apb(0, OFF_STATUS, 0); chk("loop on", 32'h1, {31'h0, q[16]});
    lbn <= 1'b0;
    apb(0, OFF_STATUS, 0); chk("loop forced off", 32'h0, {31'h0, q[16]});
    lbn <= 1'b1;
    // divide a four-cycle input by two: one rise every eight cycles
    apb(1, OFF_DIVCFG0, 32'h210);
    repeat (8) @(posedge pclk);
    c = 7'h00;
    e = dout[0];
    repeat (32) begin
      @(posedge pclk);
      if (dout[0] && !e) c = c + 7'h01;
      e = dout[0];
    end
    chk("divide by two", 32'h4, {25'h0, c});
    $display("test loop done");
    apb(1, OFF_OUTCFG0 + 8'h04, 32'h690);
    arm <= 1'b1;
    for (i = 0; i < 7; i++) begin
      repeat (5 + ($unsigned($random(seed)) % 20)) @(posedge pclk);
      gsel[1] <= ~gsel[1];
    end
    repeat (30) @(posedge pclk);
    chk("no glitch", 32'h1, {31'h0, min_run >= 2});
    apb(0, OFF_STATUS, 0); chk("secondary active", 32'h1, {31'h0, q[21]});
    $display("test switch done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
